// File: shared/weld_monitor_pkg.sv
// Constants, register map and carrier types of the weld nugget quality monitor
// Operation
// - Count converter pulses; the count is the weld quality coefficient.
// - Form one separate pulse total per nugget and judge that total.
// - Average quality values and show them as a three-digit decimal number.
// - Allowed range is set-point plus upper margin, minus lower margin.
// - Total above upper bound raises hot failure; below lower bound, cold failure.
// - Contamination threshold is a three-digit setting 0 to 9.99 V; comparison arrives as input.
// - Over-threshold immediately asserts the weld-current cut-off output.
// - Over-threshold latches contamination failure and cut-off for the rest of the can.
// - Nugget window follows zero-crossing; start marker at its start, stop marker at end.
// - Exactly one synchronisation pulse per can from the timing reference.
// - Blanking pulse of fixed length at an adjustable point on each can.
// - Blanking length comes from a selectable setting matching the welder model.
// - Blanking position is a delay measured from the per-can sync pulse.
// - While set-up is held, blanking pulse is routed onto the cut-off output.
// - Count pulses only inside a nugget window and outside blanking.
// - Hot or cold failures during blanking are ignored entirely.
package weld_monitor_pkg;

	localparam int AXI_ADDR_W = 6;

	localparam logic [AXI_ADDR_W-1:0] OFF_CTRL       = 6'h00;
	localparam logic [AXI_ADDR_W-1:0] OFF_SETPOINT   = 6'h04;
	localparam logic [AXI_ADDR_W-1:0] OFF_MARGINS    = 6'h08;
	localparam logic [AXI_ADDR_W-1:0] OFF_BLANK_DLY  = 6'h0C;
	localparam logic [AXI_ADDR_W-1:0] OFF_CONTAM     = 6'h10;
	localparam logic [AXI_ADDR_W-1:0] OFF_STATUS     = 6'h14;
	localparam logic [AXI_ADDR_W-1:0] OFF_LAST_TOTAL = 6'h18;
	localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_STATUS = 6'h1C;
	localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_MASK   = 6'h20;

	typedef enum logic [3:0] {
		REG_CTRL, REG_SETPOINT, REG_MARGINS, REG_BLANK_DLY, REG_CONTAM,
		REG_STATUS, REG_LAST_TOTAL, REG_IRQ_STATUS, REG_IRQ_MASK, REG_NONE
	} reg_sel_type;

	localparam int CTRL_BLANK_SEL_LSB = 0;
	localparam int CTRL_AVG_LSB       = 4;
	localparam int MARGIN_UPPER_LSB   = 16;
	localparam int STATUS_DISP_LSB    = 16;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [15:0] setpoint;
		logic [15:0] upper_margin;
		logic [15:0] lower_margin;
		logic [15:0] blank_delay_adjust;
		logic [11:0] contamination_level_setting;
		logic [1:0]  blank_length_select;
		logic [2:0]  avg_shift;
	} cfg_type;

	localparam cfg_type CFG_RST = '{
		setpoint:                    16'h01F4,
		upper_margin:                16'h0032,
		lower_margin:                16'h0032,
		blank_delay_adjust:          16'h0000,
		contamination_level_setting: 12'h500,
		blank_length_select:         2'h0,
		avg_shift:                   3'h3
	};

	typedef struct packed {
		logic can;
		logic contam;
		logic cold;
		logic hot;
	} event_type;

	localparam event_type EVENT_RST = 4'h0;

	// Blanking timebase: one tick per BLANK_TICK_US
	localparam int CLK_PERIOD_PS     = 5000;
	localparam int BLANK_TICK_US     = 10;
	localparam int BLANK_TICK_CYCLES = (BLANK_TICK_US * 1000 * 1000) / CLK_PERIOD_PS;

	localparam logic [3:0][15:0] BLANK_LEN_TICKS = {16'h0320, 16'h0190, 16'h00C8, 16'h0064};

	typedef enum logic [1:0] {
		BL_IDLE  = 2'h0,
		BL_DELAY = 2'h1,
		BL_BLANK = 2'h3
	} blank_state_type;

	localparam logic [9:0] DISPLAY_MAX = 10'h3E7;

endpackage

// File: rtl/input_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1_reg;

	// First stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end
endmodule // input_sync
`default_nettype wire

// File: rtl/weld_nugget_quality_monitor.sv
// Weld nugget quality monitor with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module weld_nugget_quality_monitor
	import weld_monitor_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  converter_pulse,
	input  wire logic                  zero_cross,
	input  wire logic                  timing_disk_reference,
	input  wire logic                  contamination_over,
	input  wire logic                  blank_setup,
	output logic [11:0]                contamination_level_setting,
	output logic                       weld_current_cutoff,
	output logic                       nugget_window,
	output logic                       nugget_start_marker,
	output logic                       nugget_stop_marker,
	output logic                       can_sync_pulse,
	output logic                       blank_pulse,
	output logic                       hot_fail,
	output logic                       cold_fail,
	output logic                       contamination_fail,
	output logic [11:0]                quality_display,
	output logic                       irq
);
	localparam int SUM_W = COUNT_W + 8;

	generate
		// Bounds are built from 16-bit set-point fields, so wider counts cannot be served
		if (COUNT_W < 10 || COUNT_W > 16) begin : g_bad_width
			$error("COUNT_W must lie between 10 and 16");
		end
	endgenerate

	function automatic reg_sel_type decode(input logic [AXI_ADDR_W-1:0] a);
		case (a)
			OFF_CTRL:       decode = REG_CTRL;
			OFF_SETPOINT:   decode = REG_SETPOINT;
			OFF_MARGINS:    decode = REG_MARGINS;
			OFF_BLANK_DLY:  decode = REG_BLANK_DLY;
			OFF_CONTAM:     decode = REG_CONTAM;
			OFF_STATUS:     decode = REG_STATUS;
			OFF_LAST_TOTAL: decode = REG_LAST_TOTAL;
			OFF_IRQ_STATUS: decode = REG_IRQ_STATUS;
			OFF_IRQ_MASK:   decode = REG_IRQ_MASK;
			default:        decode = REG_NONE;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	function automatic logic [11:0] to_bcd(input logic [9:0] bin);
		logic [21:0] sh;
		sh = {12'h000, bin};
		for (int i = 0; i < 10; i++) begin
			for (int d = 0; d < 3; d++) begin
				if (sh[10 + d*4 +: 4] > 4'h4) begin
					sh[10 + d*4 +: 4] = sh[10 + d*4 +: 4] + 4'h3;
				end
			end
			sh = {sh[20:0], 1'b0};
		end
		to_bcd = sh[21:10];
	endfunction

	// Synchronised inputs
	logic [4:0] sync_s;
	logic       pulse_s;
	logic       win_s;
	logic       ref_s;
	logic       over_s;
	logic       setup_s;

	input_sync #(.W(5)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({converter_pulse, zero_cross, timing_disk_reference,
			contamination_over, blank_setup}),
		.sync_out (sync_s)
	);

	assign {pulse_s, win_s, ref_s, over_s, setup_s} = sync_s;

	// Register state
	cfg_type             cfg_reg;
	event_type           irq_status_reg;
	event_type           irq_mask_reg;
	logic [COUNT_W-1:0]  last_total_reg;
	logic [AXI_ADDR_W-1:0] wr_addr_reg;
	logic [31:0]         wr_data_reg;
	logic [3:0]          wr_strb_reg;

	// Edge detection and event terms
	logic pulse_d_reg;
	logic win_d_reg;
	logic ref_d_reg;
	logic win_rise;
	logic win_fall;
	logic can_sync;
	logic count_en;
	logic blanking;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_d_reg <= 1'b0;
			win_d_reg   <= 1'b0;
			ref_d_reg   <= 1'b0;
		end else begin
			pulse_d_reg <= pulse_s;
			win_d_reg   <= win_s;
			ref_d_reg   <= ref_s;
		end
	end

	assign win_rise = win_s & ~win_d_reg;
	assign win_fall = ~win_s & win_d_reg;
	assign can_sync = ref_s & ~ref_d_reg;
	assign count_en = win_s & ~blanking & pulse_s & ~pulse_d_reg;

	// Blanking timebase and sequencer
	logic [$clog2(BLANK_TICK_CYCLES)-1:0] tick_cnt_reg;
	logic                                 tick;
	blank_state_type                      bl_state_reg;
	blank_state_type                      bl_state_next;
	logic [15:0]                          bl_cnt_reg;
	logic [15:0]                          bl_cnt_next;

	assign tick = (tick_cnt_reg == ($clog2(BLANK_TICK_CYCLES))'(BLANK_TICK_CYCLES - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end

	always_comb begin
		bl_state_next = bl_state_reg;
		bl_cnt_next   = bl_cnt_reg;
		if (can_sync) begin
			bl_state_next = BL_DELAY;
			bl_cnt_next   = '0;
		end else if (tick) begin
			case (bl_state_reg)
				BL_IDLE: begin
					bl_cnt_next = '0;
				end
				BL_DELAY: begin
					if (bl_cnt_reg >= cfg_reg.blank_delay_adjust) begin
						bl_state_next = BL_BLANK;
						bl_cnt_next   = '0;
					end else begin
						bl_cnt_next = bl_cnt_reg + 16'h0001;
					end
				end
				BL_BLANK: begin
					// Length fixed by the welder-model selection
					if (bl_cnt_reg >= BLANK_LEN_TICKS[cfg_reg.blank_length_select] - 16'h0001) begin
						bl_state_next = BL_IDLE;
						bl_cnt_next   = '0;
					end else begin
						bl_cnt_next = bl_cnt_reg + 16'h0001;
					end
				end
				default: begin
					bl_state_next = BL_IDLE;
					bl_cnt_next   = '0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bl_state_reg <= BL_IDLE;
			bl_cnt_reg   <= '0;
		end else begin
			bl_state_reg <= bl_state_next;
			bl_cnt_reg   <= bl_cnt_next;
		end
	end

	assign blanking = (bl_state_reg == BL_BLANK);

	// Nugget counting and judgement
	logic [COUNT_W-1:0] nug_cnt_reg;
	logic [COUNT_W:0]   upper_bound;
	logic [COUNT_W:0]   lower_bound;
	logic               judge;
	logic               hot_evt;
	logic               cold_evt;

	always_ff @(posedge aclk) begin
		if (!aresetn || win_rise) begin
			nug_cnt_reg <= '0;
		end else if (count_en && nug_cnt_reg != '1) begin
			nug_cnt_reg <= nug_cnt_reg + 1'b1;
		end
	end

	// Margins are truncated to COUNT_W; lower bound saturates at zero
	assign upper_bound = {1'b0, cfg_reg.setpoint[COUNT_W-1:0]}
		+ {1'b0, cfg_reg.upper_margin[COUNT_W-1:0]};
	assign lower_bound = (cfg_reg.setpoint >= cfg_reg.lower_margin)
		? {1'b0, cfg_reg.setpoint[COUNT_W-1:0] - cfg_reg.lower_margin[COUNT_W-1:0]}
		: '0;
	assign judge    = win_fall & ~blanking;
	assign hot_evt  = judge & ({1'b0, nug_cnt_reg} > upper_bound);
	assign cold_evt = judge & ({1'b0, nug_cnt_reg} < lower_bound);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_total_reg <= '0;
		end else if (win_fall) begin
			last_total_reg <= nug_cnt_reg;
		end
	end

	// Averaging over 2^avg_shift judged nuggets
	logic [SUM_W-1:0]   sum_reg;
	logic [SUM_W-1:0]   sum_next;
	logic [7:0]         avg_n_reg;
	logic [COUNT_W-1:0] avg_val;

	assign sum_next = sum_reg + {8'h00, nug_cnt_reg};
	assign avg_val  = COUNT_W'(sum_next >> cfg_reg.avg_shift);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sum_reg         <= '0;
			avg_n_reg       <= '0;
			quality_display <= '0;
		end else if (judge) begin
			if (avg_n_reg >= (8'h01 << cfg_reg.avg_shift) - 8'h01) begin
				sum_reg   <= '0;
				avg_n_reg <= '0;
				// Display saturates at 999
				quality_display <= to_bcd((avg_val > COUNT_W'(DISPLAY_MAX))
					? DISPLAY_MAX : avg_val[9:0]);
			end else begin
				sum_reg   <= sum_next;
				avg_n_reg <= avg_n_reg + 8'h01;
			end
		end
	end

	// Failure latches: a new event in the can-sync cycle stays set
	logic contam_latch_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			contam_latch_reg <= 1'b0;
			hot_fail         <= 1'b0;
			cold_fail        <= 1'b0;
		end else begin
			contam_latch_reg <= over_s | (contam_latch_reg & ~can_sync);
			hot_fail         <= hot_evt | (hot_fail & ~can_sync);
			cold_fail        <= cold_evt | (cold_fail & ~can_sync);
		end
	end

	// Pin outputs; cut-off follows the live comparator too, so no latch delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			weld_current_cutoff         <= 1'b0;
			contamination_fail          <= 1'b0;
			nugget_window               <= 1'b0;
			nugget_start_marker         <= 1'b0;
			nugget_stop_marker          <= 1'b0;
			can_sync_pulse              <= 1'b0;
			blank_pulse                 <= 1'b0;
			contamination_level_setting <= CFG_RST.contamination_level_setting;
		end else begin
			weld_current_cutoff <= over_s | (contam_latch_reg & ~can_sync)
				| (setup_s & blanking);
			contamination_fail          <= over_s | (contam_latch_reg & ~can_sync);
			nugget_window               <= win_s;
			nugget_start_marker         <= win_rise;
			nugget_stop_marker          <= win_fall;
			can_sync_pulse              <= can_sync;
			blank_pulse                 <= blanking;
			contamination_level_setting <= cfg_reg.contamination_level_setting;
		end
	end

	// AXI4-Lite write channel
	logic      do_write;
	event_type events;

	assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign events   = '{can: can_sync, contam: over_s & ~contam_latch_reg,
		cold: cold_evt, hot: hot_evt};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			wr_addr_reg   <= '0;
			wr_data_reg   <= '0;
			wr_strb_reg   <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wr_addr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wr_data_reg  <= s_axi_wdata;
				wr_strb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (decode(wr_addr_reg) == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Configuration and interrupt registers
	logic [31:0] wmerged;
	logic [31:0] w1c;

	always_comb begin
		wmerged = 32'h0000_0000;
		w1c     = 32'h0000_0000;
		case (decode(wr_addr_reg))
			REG_CTRL: wmerged = merge({25'h0, cfg_reg.avg_shift, 2'h0,
				cfg_reg.blank_length_select}, wr_data_reg, wr_strb_reg);
			REG_SETPOINT: wmerged = merge({16'h0, cfg_reg.setpoint}, wr_data_reg, wr_strb_reg);
			REG_MARGINS: wmerged = merge({cfg_reg.upper_margin, cfg_reg.lower_margin},
				wr_data_reg, wr_strb_reg);
			REG_BLANK_DLY: wmerged = merge({16'h0, cfg_reg.blank_delay_adjust},
				wr_data_reg, wr_strb_reg);
			REG_CONTAM: wmerged = merge({20'h0, cfg_reg.contamination_level_setting},
				wr_data_reg, wr_strb_reg);
			REG_IRQ_MASK: wmerged = merge({28'h0, irq_mask_reg}, wr_data_reg, wr_strb_reg);
			REG_IRQ_STATUS: w1c = merge(32'h0, wr_data_reg, wr_strb_reg);
			default: wmerged = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg      <= CFG_RST;
			irq_mask_reg <= EVENT_RST;
		end else if (do_write) begin
			case (decode(wr_addr_reg))
				REG_CTRL: begin
					cfg_reg.blank_length_select <= wmerged[CTRL_BLANK_SEL_LSB +: 2];
					cfg_reg.avg_shift           <= wmerged[CTRL_AVG_LSB +: 3];
				end
				REG_SETPOINT:  cfg_reg.setpoint <= wmerged[15:0];
				REG_MARGINS: begin
					cfg_reg.upper_margin <= wmerged[MARGIN_UPPER_LSB +: 16];
					cfg_reg.lower_margin <= wmerged[15:0];
				end
				REG_BLANK_DLY: cfg_reg.blank_delay_adjust <= wmerged[15:0];
				REG_CONTAM:    cfg_reg.contamination_level_setting <= wmerged[11:0];
				REG_IRQ_MASK:  irq_mask_reg <= wmerged[3:0];
				default:       cfg_reg <= cfg_reg;
			endcase
		end
	end

	// Sticky status: a same-cycle event beats the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= EVENT_RST;
			irq            <= 1'b0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~(do_write ? w1c[3:0] : 4'h0)) | events;
			irq            <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case (decode(s_axi_araddr))
				REG_CTRL: s_axi_rdata <= {25'h0, cfg_reg.avg_shift, 2'h0,
					cfg_reg.blank_length_select};
				REG_SETPOINT:   s_axi_rdata <= {16'h0, cfg_reg.setpoint};
				REG_MARGINS:    s_axi_rdata <= {cfg_reg.upper_margin, cfg_reg.lower_margin};
				REG_BLANK_DLY:  s_axi_rdata <= {16'h0, cfg_reg.blank_delay_adjust};
				REG_CONTAM:     s_axi_rdata <= {20'h0, cfg_reg.contamination_level_setting};
				REG_STATUS: s_axi_rdata <= {4'h0, quality_display, 11'h000, win_s, blanking,
					contam_latch_reg, cold_fail, hot_fail};
				REG_LAST_TOTAL: s_axi_rdata <= 32'(last_total_reg);
				REG_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status_reg};
				REG_IRQ_MASK:   s_axi_rdata <= {28'h0, irq_mask_reg};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // weld_nugget_quality_monitor
`default_nettype wire

// File: bench/weld_monitor_checker_sva.sv
// Port-level assertion checker for the weld nugget quality monitor
`timescale 1ns/1ps
`default_nettype none
module weld_monitor_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        zero_cross,
	input wire logic        timing_disk_reference,
	input wire logic        contamination_over,
	input wire logic        blank_setup,
	input wire logic        nugget_window,
	input wire logic        nugget_start_marker,
	input wire logic        nugget_stop_marker,
	input wire logic        can_sync_pulse,
	input wire logic        weld_current_cutoff,
	input wire logic        contamination_fail,
	input wire logic        hot_fail,
	input wire logic        cold_fail,
	input wire logic        blank_pulse,
	input wire logic [11:0] quality_display
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Two sync flops plus the pin output register give three edges of lag on every pin
	sequence s_zc_up; $rose(zero_cross); endsequence
	sequence s_zc_down; $fell(zero_cross); endsequence
	sequence s_setup_held; blank_setup [*5]; endsequence
	a_start_mark: assert property (s_zc_up |->
		##3 (nugget_start_marker && nugget_window)) else $error("start marker missing");
	a_stop_mark: assert property (s_zc_down |-> ##3 nugget_stop_marker)
		else $error("stop marker missing");
	a_can_sync: assert property ($rose(timing_disk_reference) |-> ##3 can_sync_pulse)
		else $error("can sync pulse missing");
	a_one_sync: assert property (can_sync_pulse |=> !can_sync_pulse)
		else $error("can sync pulse too long");
	a_cutoff_fast: assert property ($rose(contamination_over) |-> ##3 weld_current_cutoff)
		else $error("cut-off late");
	a_contam_latch: assert property (contamination_fail |-> weld_current_cutoff)
		else $error("latched failure without cut-off");
	a_latch_clear: assert property ($fell(contamination_fail) |->
		can_sync_pulse || $past(can_sync_pulse)) else $error("latch cleared outside can sync");
	a_fail_judged: assert property ($rose(hot_fail) || $rose(cold_fail) |-> nugget_stop_marker)
		else $error("failure not at nugget end");
	a_setup_route: assert property (s_setup_held ##0 (blank_pulse && $past(blank_pulse))
		|-> weld_current_cutoff) else $error("blanking not on cut-off in set-up");
	a_digit_bcd: assert property (quality_display[3:0] <= 4'h9 && quality_display[7:4] <= 4'h9
		&& quality_display[11:8] <= 4'h9) else $error("display digit not decimal");
endmodule // weld_monitor_checker
bind weld_nugget_quality_monitor weld_monitor_checker i_weld_monitor_checker (.aclk, .aresetn,
	.zero_cross, .timing_disk_reference, .contamination_over, .blank_setup, .nugget_start_marker,
	.nugget_stop_marker, .can_sync_pulse, .weld_current_cutoff, .contamination_fail, .hot_fail,
	.cold_fail, .blank_pulse, .nugget_window, .quality_display);
`default_nettype wire

// File: bench/weld_timing_model.sv
// Welder side model: converter pulses, zero-crossing, per-can reference, comparator
`timescale 1ns/1ps
`default_nettype none
module weld_timing_model (
	input wire logic aclk,
	output logic     converter_pulse,
	output logic     zero_cross,
	output logic     timing_disk_reference,
	output logic     contamination_over
);
	initial begin
		converter_pulse = 1'b0;
		zero_cross = 1'b0;
		timing_disk_reference = 1'b0;
		contamination_over = 1'b0;
	end
	// Two cycles high and low so the synchroniser never misses an edge
	task automatic pulse();
		converter_pulse <= 1'b1;
		repeat (2) @(posedge aclk);
		converter_pulse <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	// Stray pulses come first, outside the window, and must not count
	task automatic nugget(input int n);
		@(posedge aclk);
		repeat (3) pulse();
		zero_cross <= 1'b1;
		repeat (4) @(posedge aclk);
		repeat (n) pulse();
		repeat (2) @(posedge aclk);
		zero_cross <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	task automatic spike(input logic can);
		@(posedge aclk);
		if (can) timing_disk_reference <= 1'b1;
		else contamination_over <= 1'b1;
		repeat (4) @(posedge aclk);
		timing_disk_reference <= 1'b0;
		contamination_over <= 1'b0;
	endtask
endmodule // weld_timing_model
`default_nettype wire

// File: bench/weld_nugget_quality_monitor_tb.sv
// Self-checking testbench for the weld nugget quality monitor
`timescale 1ns/1ps
`default_nettype none
module weld_nugget_quality_monitor_tb;
	import weld_monitor_pkg::*;
	logic        aclk, aresetn, blank_setup;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        converter_pulse, zero_cross, timing_disk_reference, contamination_over;
	logic        weld_current_cutoff, nugget_window, nugget_start_marker, nugget_stop_marker;
	logic        can_sync_pulse, blank_pulse, hot_fail, cold_fail, contamination_fail, irq;
	logic [11:0] contamination_level_setting, quality_display;
	int          n_mismatch = 0, samples_checked = 0, cycles = 0, n_can = 0;
	int          tot [4] = '{15, 25, 26, 14};
	logic [1:0]  exp_hc [4] = '{2'h0, 2'h0, 2'h2, 2'h3};
	logic [5:0]  ra [6] = '{OFF_CTRL, OFF_SETPOINT, OFF_MARGINS, OFF_BLANK_DLY, OFF_CONTAM,
		OFF_IRQ_MASK};
	logic [31:0] rv [6] = '{32'h30, 32'h1F4, 32'h320032, 32'h0, 32'h500, 32'h0};

	weld_nugget_quality_monitor i_weld_nugget_quality_monitor (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .converter_pulse, .zero_cross, .timing_disk_reference,
		.contamination_over, .blank_setup, .contamination_level_setting, .weld_current_cutoff,
		.nugget_window, .nugget_start_marker, .nugget_stop_marker, .can_sync_pulse,
		.blank_pulse, .hot_fail, .cold_fail, .contamination_fail, .quality_display, .irq);
	weld_timing_model i_weld_timing_model (.aclk, .converter_pulse, .zero_cross,
		.timing_disk_reference, .contamination_over);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	always @(negedge aclk) if (aresetn === 1'b1 && can_sync_pulse === 1'b1) n_can++;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Looks at the ports on the falling edge, where nothing is changing
	task automatic wt(input int n);
		repeat (n) @(negedge aclk);
	endtask
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
		logic aw, w, b;
		rsp = 2'h3;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [5:0] a);
		logic ar, r;
		rsp = 2'h3;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	initial begin
		aresetn = 1'b0;
		blank_setup = 1'b0;
		s_axi_awaddr = 6'h00;
		s_axi_araddr = 6'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			axi_rd(ra[i]);
			chk(rd, rv[i]);
		end
		axi_rd(6'h24);
		chk({rd[29:0], rsp}, 32'h2);
		axi_wr(6'h24, 32'hFFFFFFFF);
		chk(32'(rsp), 32'h2);
		axi_wr(OFF_CONTAM, 32'h999);
		wt(2);
		chk(32'(contamination_level_setting), 32'h999);
		axi_wr(OFF_CTRL, 32'h20);
		axi_wr(OFF_SETPOINT, 32'h14);
		axi_wr(OFF_MARGINS, 32'h50005);
		// Totals sit on and just past both bounds of 20 plus 5, minus 5
		for (int i = 0; i < 4; i++) begin
			i_weld_timing_model.nugget(tot[i]);
			axi_rd(OFF_LAST_TOTAL);
			chk(rd, 32'(tot[i]));
			wt(1);
			chk(32'({hot_fail, cold_fail}), 32'(exp_hc[i]));
		end
		chk(32'(quality_display), 32'h020);
		axi_rd(OFF_IRQ_STATUS);
		chk(rd, 32'h3);
		wt(2);
		chk(32'(irq), 32'h0);
		axi_wr(OFF_IRQ_MASK, 32'hF);
		wt(2);
		chk(32'(irq), 32'h1);
		axi_wr(OFF_IRQ_MASK, 32'h0);
		axi_wr(OFF_IRQ_STATUS, 32'hF);
		axi_rd(OFF_IRQ_STATUS);
		chk(rd, 32'h0);
		i_weld_timing_model.spike(1'b0);
		wt(3);
		chk(32'({weld_current_cutoff, contamination_fail}), 32'h3);
		wt(20);
		chk(32'({weld_current_cutoff, contamination_fail}), 32'h3);
		i_weld_timing_model.spike(1'b1);
		wt(3);
		chk(32'({weld_current_cutoff, contamination_fail, hot_fail, cold_fail}), 32'h0);
		chk(32'(n_can), 32'h1);
		for (int k = 0; k < 2100 && blank_pulse !== 1'b1; k++) wt(1);
		chk(32'(blank_pulse), 32'h1);
		i_weld_timing_model.nugget(30);
		wt(1);
		chk(32'({hot_fail, cold_fail}), 32'h0);
		axi_rd(OFF_LAST_TOTAL);
		chk(rd, 32'h0);
		@(posedge aclk);
		blank_setup <= 1'b1;
		wt(8);
		chk(32'(weld_current_cutoff), 32'h1);
		@(posedge aclk);
		aresetn <= 1'b0;
		blank_setup <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		wt(2);
		chk(32'({blank_pulse, weld_current_cutoff, contamination_fail}), 32'h0);
		stop_test();
	end
endmodule // weld_nugget_quality_monitor_tb
`default_nettype wire
